// File: rtl/cel_db_conv.sv
// linear magnitude to logarithmic level code converter
// purely combinational; the caller registers the result
`timescale 1ns/10ps
`default_nettype none
module cel_db_conv
    import cel_pkg::*;
#(
    parameter int IN_W = CEL_LVL_IN_W
) (
    // linear magnitude, full scale at 2**IN_W
    input wire logic [IN_W-1:0] lin,
    // level code, 0.375 dB per step from -96 dB
    output logic [CEL_CODE_W-1:0] code
);

    // octave from leading one, fraction from the next four bits
    // piecewise-linear log2, below the true level by up to about 2.4 code steps
    always_comb begin
        int msb;
        int oct;
        logic [IN_W-1:0] norm;
        msb = 0;
        oct = 0;
        norm = '0;
        for (int i = 0; i < IN_W; i++) begin
            if (lin[i]) begin
                msb = i;
            end
        end
        norm = lin << (IN_W - 1 - msb);
        oct = msb - (IN_W - CEL_CODES_OCT);
        if (lin == '0 || oct < 0) begin
            code = '0; // floor at -96 dB
        end else begin
            code = {oct[3:0], norm[IN_W-2 -: CEL_FRAC_W]};
        end
    end

endmodule : cel_db_conv
`default_nettype wire

// File: rtl/cel_pkg.sv
// constants and carrier types for the core enable and level readout block
// assumes an 8-bit host register port and a single 50 MHz clock
package cel_pkg;

    // host register map
    localparam logic [7:0] CEL_OFS_CTRL = 8'h0b;
    localparam logic [7:0] CEL_OFS_LVL0 = 8'h0c;
    localparam logic [7:0] CEL_OFS_LVL1 = 8'h0d;
    localparam logic [7:0] CEL_OFS_LVL2 = 8'h0e;

    // control register layout and reset
    localparam logic [7:0] CEL_CTRL_RESET = 8'h03;
    localparam logic [7:0] CEL_CTRL_MASK = 8'h03;
    localparam int CEL_BIT_CLK_EN = 0;
    localparam int CEL_BIT_LIMITER_ATTACK_ENABLE = 1;

    // level readouts
    localparam int CEL_LVL_NUM = 3;
    localparam int CEL_CODE_W = 8;
    localparam logic [7:0] CEL_LVL_RESET = 8'h00;
    localparam logic [7:0] CEL_UNMAPPED = 8'h00;
    localparam int CEL_LVL_IN_W = 24;
    // 0.375 dB per code, 6 dB per octave gives 16 codes per octave
    localparam int CEL_CODES_OCT = 16;
    localparam int CEL_FRAC_W = 4;

    // parameter memory write path and biquad window
    localparam int CEL_PM_ADDR_W = 10;
    localparam int CEL_PM_DATA_W = 32;
    localparam logic [9:0] CEL_PM_BIQ_LO = 10'h0e0;
    localparam logic [9:0] CEL_PM_BIQ_HI = 10'h2bf;

    // host register access request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cel_host_req_t;

    // parameter memory write
    typedef struct packed {
        logic valid;
        logic [CEL_PM_ADDR_W-1:0] addr;
        logic [CEL_PM_DATA_W-1:0] data;
    } cel_pm_wr_t;

    // core program write into a level register
    typedef struct packed {
        logic valid;
        logic [1:0] sel;
        logic [CEL_LVL_IN_W-1:0] value;
    } cel_lvl_wr_t;

endpackage : cel_pkg

// File: rtl/cel_regs.sv
// core clock / limiter control register and three level readouts
// host side is a plain register port decoded by the control interface;
// core side writes level values; parameter memory writes pass through, except biquad window writes while the core clock is gated
`timescale 1ns/10ps
`default_nettype none

module cel_regs
    import cel_pkg::*;
#(
    parameter int LVL_IN_W = CEL_LVL_IN_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // host register port
    input wire cel_host_req_t host_req,
    output logic [7:0] host_rd_data,
    output logic host_rd_valid,
    // host parameter memory writes and their forwarded copy
    input wire cel_pm_wr_t pm_in,
    output cel_pm_wr_t pm_out,
    output logic pm_blocked,
    // core program level writes
    input wire cel_lvl_wr_t lvl_wr,
    // controls to the processing core
    output logic core_clk_en,
    output logic limiter_attack_enable,
    output logic limiter_decay_enable,
    output logic limiter_fixed_max_gain
);

    // control register state
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;

    // derived control outputs, registered
    logic core_clk_en_reg;
    logic core_clk_en_next;
    logic lim_attack_reg;
    logic lim_attack_next;
    logic lim_decay_reg;
    logic lim_decay_next;
    logic lim_fixed_reg;
    logic lim_fixed_next;

    // read answer state
    logic [7:0] rd_data_reg;
    logic [7:0] rd_data_next;
    logic rd_valid_reg;
    logic rd_valid_next;

    // parameter memory forwarding state
    cel_pm_wr_t pm_reg;
    cel_pm_wr_t pm_next;
    logic pm_blk_reg;
    logic pm_blk_next;
    logic pm_in_biquad;

    // level readouts
    logic [CEL_CODE_W-1:0] lvl_reg [CEL_LVL_NUM];
    logic [CEL_CODE_W-1:0] lvl_next [CEL_LVL_NUM];
    logic [CEL_CODE_W-1:0] conv_code;

    // single converter: the core writes one level per cycle at most
    cel_db_conv #(
        .IN_W(LVL_IN_W)
    ) u_conv (
        .lin(lvl_wr.value[LVL_IN_W-1:0]),
        .code(conv_code)
    );

    // control register: only the two defined bits are stored,
    // so the reserved field can never read back anything but zero
    always_comb begin
        ctrl_next = ctrl_reg;
        if (host_req.wr && host_req.addr == CEL_OFS_CTRL) begin
            ctrl_next = host_req.wdata & CEL_CTRL_MASK;
        end
    end

    // control outputs follow the stored bits one cycle after the write
    always_comb begin
        core_clk_en_next = ctrl_next[CEL_BIT_CLK_EN];
        lim_attack_next = ctrl_next[CEL_BIT_LIMITER_ATTACK_ENABLE];
        // gain recovery never depends on the enable
        lim_decay_next = 1'b1;
        lim_fixed_next = ~ctrl_next[CEL_BIT_LIMITER_ATTACK_ENABLE];
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_reg <= CEL_CTRL_RESET;
            core_clk_en_reg <= CEL_CTRL_RESET[CEL_BIT_CLK_EN];
            lim_attack_reg <= CEL_CTRL_RESET[CEL_BIT_LIMITER_ATTACK_ENABLE];
            lim_decay_reg <= 1'b1;
            lim_fixed_reg <= ~CEL_CTRL_RESET[CEL_BIT_LIMITER_ATTACK_ENABLE];
        end else begin
            ctrl_reg <= ctrl_next;
            core_clk_en_reg <= core_clk_en_next;
            lim_attack_reg <= lim_attack_next;
            lim_decay_reg <= lim_decay_next;
            lim_fixed_reg <= lim_fixed_next;
        end
    end

    // biquad window check on the incoming parameter address
    assign pm_in_biquad = (pm_in.addr >= CEL_PM_BIQ_LO) &&
        (pm_in.addr <= CEL_PM_BIQ_HI);

    // parameter memory writes: coefficient writes are dropped while the
    // core clock is gated, since the coefficient ram runs on that clock
    always_comb begin
        pm_next = pm_in;
        pm_blk_next = 1'b0;
        if (pm_in.valid && pm_in_biquad &&
            !ctrl_reg[CEL_BIT_CLK_EN]) begin
            pm_next.valid = 1'b0;
            pm_blk_next = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pm_reg <= '0;
            pm_blk_reg <= 1'b0;
        end else begin
            pm_reg <= pm_next;
            pm_blk_reg <= pm_blk_next;
        end
    end

    // level registers: written only by the core, host writes ignored.
    // a stopped core clock means no program runs, so writes then drop
    for (genvar g = 0; g < CEL_LVL_NUM; g++) begin : g_lvl
        always_comb begin
            lvl_next[g] = lvl_reg[g];
            if (lvl_wr.valid && ctrl_reg[CEL_BIT_CLK_EN] &&
                lvl_wr.sel == 2'(g)) begin
                lvl_next[g] = conv_code;
            end
        end

        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                lvl_reg[g] <= CEL_LVL_RESET;
            end else begin
                lvl_reg[g] <= lvl_next[g];
            end
        end
    end

    // read decode; unmapped addresses answer zero
    always_comb begin
        rd_data_next = rd_data_reg;
        rd_valid_next = 1'b0;
        if (host_req.rd) begin
            rd_valid_next = 1'b1;
            case (host_req.addr)
                CEL_OFS_CTRL: begin
                    rd_data_next = ctrl_reg;
                end
                CEL_OFS_LVL0: begin
                    rd_data_next = lvl_reg[0];
                end
                CEL_OFS_LVL1: begin
                    rd_data_next = lvl_reg[1];
                end
                CEL_OFS_LVL2: begin
                    rd_data_next = lvl_reg[2];
                end
                default: begin
                    rd_data_next = CEL_UNMAPPED;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data_reg <= 8'h00;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_data_reg <= rd_data_next;
            rd_valid_reg <= rd_valid_next;
        end
    end

    // outputs straight from flops
    assign host_rd_data = rd_data_reg;
    assign host_rd_valid = rd_valid_reg;
    assign pm_out = pm_reg;
    assign pm_blocked = pm_blk_reg;
    assign core_clk_en = core_clk_en_reg;
    assign limiter_attack_enable = lim_attack_reg;
    assign limiter_decay_enable = lim_decay_reg;
    assign limiter_fixed_max_gain = lim_fixed_reg;

endmodule : cel_regs
`default_nettype wire

// File: verif/cel_regs_chk.sv
// assertions on the control and level readout register ports
// assumes one clock domain and an active-high async reset
`timescale 1ns/10ps
`default_nettype none
module cel_regs_chk
    import cel_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // watched ports
    input wire cel_host_req_t host_req,
    input wire logic [7:0] host_rd_data,
    input wire logic host_rd_valid,
    input wire cel_pm_wr_t pm_in,
    input wire cel_pm_wr_t pm_out,
    input wire logic pm_blocked,
    input wire cel_lvl_wr_t lvl_wr,
    input wire logic core_clk_en,
    input wire logic limiter_attack_enable,
    input wire logic limiter_decay_enable,
    input wire logic limiter_fixed_max_gain
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic ctrl_wr;
    logic biq;
    // decoded causes, kept out of the properties for readability
    assign ctrl_wr = host_req.wr && host_req.addr == CEL_OFS_CTRL;
    assign biq = pm_in.valid && pm_in.addr >= CEL_PM_BIQ_LO
        && pm_in.addr <= CEL_PM_BIQ_HI;
    // host port answers and control register effects
    rd_answer_a: assert property (host_req.rd |=> host_rd_valid)
        else $error("read not answered");
    rd_quiet_a: assert property (!host_req.rd |=> !host_rd_valid)
        else $error("spurious read answer");
    ctrl_read_a: assert property (
        host_req.rd && host_req.addr == CEL_OFS_CTRL
        |=> host_rd_data == {6'h00, $past(limiter_attack_enable),
        $past(core_clk_en)}) else $error("control readback wrong");
    clk_gate_a: assert property (ctrl_wr
        |=> core_clk_en == $past(host_req.wdata[0]))
        else $error("clock gate not taken");
    lim_bit_a: assert property (ctrl_wr
        |=> limiter_attack_enable == $past(host_req.wdata[1]))
        else $error("limiter enable not taken");
    gate_hold_a: assert property (!ctrl_wr
        |=> $stable({core_clk_en, limiter_attack_enable}))
        else $error("control changed without write");
    max_gain_a: assert property (
        limiter_fixed_max_gain != limiter_attack_enable)
        else $error("fixed gain not inverse of enable");
    decay_on_a: assert property (limiter_decay_enable)
        else $error("decay stopped");
    // biquad window guard on parameter memory writes
    biq_block_a: assert property (biq && !core_clk_en
        |=> pm_blocked && !pm_out.valid) else $error("biquad write leaked");
    pm_pass_a: assert property (pm_in.valid && (core_clk_en || !biq)
        |=> pm_out.valid && !pm_blocked) else $error("write wrongly blocked");
    cover property (ctrl_wr);
    cover property (biq && !core_clk_en);
    cover property (lvl_wr.valid && core_clk_en);
endmodule : cel_regs_chk

bind cel_regs cel_regs_chk u_chk (.clk(clk), .sys_rst(sys_rst),
    .host_req(host_req), .host_rd_data(host_rd_data),
    .host_rd_valid(host_rd_valid), .pm_in(pm_in), .pm_out(pm_out),
    .pm_blocked(pm_blocked), .lvl_wr(lvl_wr), .core_clk_en(core_clk_en),
    .limiter_attack_enable(limiter_attack_enable),
    .limiter_decay_enable(limiter_decay_enable),
    .limiter_fixed_max_gain(limiter_fixed_max_gain));
`default_nettype wire

// File: verif/tb_top.sv
// self-checking bench for the control and level readout registers
// drives every port of cel_regs itself, 2 ns after each rising edge
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import cel_pkg::*;
;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    cel_host_req_t host_req = '0;
    cel_pm_wr_t pm_in = '0;
    cel_lvl_wr_t lvl_wr = '0;
    cel_pm_wr_t pm_out;
    logic [7:0] host_rd_data;
    logic host_rd_valid, pm_blocked, core_clk_en, limiter_attack_enable;
    logic limiter_decay_enable, limiter_fixed_max_gain;
    int error_cnt = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [23:0] vals [9] = '{24'h000100, 24'h000200, 24'h000400,
        24'h000800, 24'h400000, 24'h800000, 24'hffffff, 24'h000180,
        24'h0000ff};
    logic [7:0] codes [9] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'he0, 8'hf0,
        8'hff, 8'h08, 8'h00};

    cel_regs uut (.clk(clk), .sys_rst(sys_rst), .host_req(host_req),
        .host_rd_data(host_rd_data), .host_rd_valid(host_rd_valid),
        .pm_in(pm_in), .pm_out(pm_out), .pm_blocked(pm_blocked),
        .lvl_wr(lvl_wr), .core_clk_en(core_clk_en),
        .limiter_attack_enable(limiter_attack_enable),
        .limiter_decay_enable(limiter_decay_enable),
        .limiter_fixed_max_gain(limiter_fixed_max_gain));

    // 50 MHz clock and a hang guard well past the expected run
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            give_verdict();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic host_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk); #2;
        host_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk); #2;
        host_req.wr = 1'b0;
    endtask : host_wr

    // read answer is launched by the very edge that takes the request
    // and its valid pulse lasts only until the next edge
    task automatic host_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk); #2;
        host_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk); #2;
        check(host_rd_valid, 1'b1);
        check(host_rd_data, exp);
        host_req.rd = 1'b0;
    endtask : host_rd

    task automatic pm_wr(input logic [9:0] a, input logic blk);
        @(posedge clk); #2;
        pm_in = '{valid: 1'b1, addr: a, data: 32'h5a5a_0f0f};
        @(posedge clk); #2;
        check({pm_blocked, pm_out.valid, pm_out.addr}, {blk, !blk, a});
        check(pm_out.data, 32'h5a5a_0f0f);
        pm_in.valid = 1'b0;
    endtask : pm_wr

    // control outputs: {clk_en, attack, decay, fixed gain}
    task automatic ctrl_scn();
        check({core_clk_en, limiter_attack_enable, limiter_decay_enable,
            limiter_fixed_max_gain}, 4'he);
        host_wr(CEL_OFS_CTRL, 8'hfc);
        host_rd(CEL_OFS_CTRL, 8'h00);
        check({core_clk_en, limiter_attack_enable, limiter_decay_enable,
            limiter_fixed_max_gain}, 4'h3);
        host_wr(CEL_OFS_CTRL, 8'h02);
        check({core_clk_en, limiter_attack_enable}, 2'h1);
    endtask : ctrl_scn

    // window edges both sides while gated, then with the clock running
    task automatic biq_scn();
        pm_wr(10'h0df, 1'b0);
        pm_wr(CEL_PM_BIQ_LO, 1'b1);
        pm_wr(CEL_PM_BIQ_HI, 1'b1);
        pm_wr(10'h2c0, 1'b0);
        // gate reopened only while no core write is in flight
        host_wr(CEL_OFS_CTRL, 8'h01);
        pm_wr(CEL_PM_BIQ_LO, 1'b0);
        pm_wr(CEL_PM_BIQ_HI, 1'b0);
    endtask : biq_scn

    // core writes linear values, host reads back the level codes
    task automatic lvl_scn();
        for (int i = 0; i < 9; i++) begin
            @(posedge clk); #2;
            lvl_wr = '{valid: 1'b1, sel: 2'(i % 3), value: vals[i]};
            @(posedge clk); #2;
            lvl_wr.valid = 1'b0;
            host_rd(CEL_OFS_LVL0 + 8'(i % 3), codes[i]);
        end
        host_wr(CEL_OFS_LVL2, 8'h55);
        lvl_wr = '{valid: 1'b1, sel: 2'h3, value: 24'hffffff};
        @(posedge clk); #2;
        lvl_wr.valid = 1'b0;
        host_rd(CEL_OFS_LVL2, 8'h00);
    endtask : lvl_scn

    // mid-run reset brings control and levels back to reset values
    task automatic rst_scn();
        @(posedge clk); #2;
        sys_rst = 1'b1;
        @(posedge clk); #2;
        sys_rst = 1'b0;
        host_rd(CEL_OFS_CTRL, CEL_CTRL_RESET);
        host_rd(CEL_OFS_LVL0, 8'h00);
    endtask : rst_scn

    task automatic give_verdict();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict

    // main sequence, with a second reset in mid-run
    initial begin
        repeat (4) @(posedge clk);
        #2 sys_rst = 1'b0;
        host_rd(CEL_OFS_CTRL, CEL_CTRL_RESET);
        host_rd(CEL_OFS_LVL1, 8'h00);
        ctrl_scn();
        biq_scn();
        lvl_scn();
        rst_scn();
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
